// ---- far_master.sv ----
// Far-side bus master model that sends frames to the unit.
`timescale 1ns/1ps
module far_master (
  // Resolved wire levels
  input  wire logic scl_w,
  input  wire logic sda_w,
  // Own drive, low pulls the wire, high leaves it to the pull-up
  output logic      scl_d,
  output logic      sda_d,
  // Set when a clock stretch outlasts its bound
  output logic      stuck
);
  initial begin
    scl_d = 1'b1;
    sda_d = 1'b1;
    stuck = 1'b0;
  end
  // A stretch is waited out under a bound so that a hung unit cannot hang the run.
  task automatic clk_hi();
    int n;
    scl_d = 1'b1;
    for (n = 0; n < 4000 && !scl_w; n++) #8;
    if (n == 4000) stuck = 1'b1;
    #80;
  endtask : clk_hi
  task automatic start();
    sda_d = 1'b1;
    #80;
    clk_hi();
    sda_d = 1'b0;
    #80;
    scl_d = 1'b0;
  endtask : start
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #40;
      sda_d = b[i];
      #40;
      clk_hi();
      scl_d = 1'b0;
    end
    #40;
    sda_d = 1'b1;
    #40;
    clk_hi();
    ack = ~sda_w;
    scl_d = 1'b0;
  endtask : put_byte
  task automatic fall_w();
    int n, m;
    for (n = 0; n < 4000 && !scl_w; n++) #8;
    for (m = 0; m < 4000 && scl_w; m++) #8;
    if (n == 4000 || m == 4000) stuck = 1'b1;
  endtask : fall_w
  // Acts as an addressed slave: pulls data low through the ninth clock of the unit's byte.
  task automatic ack_byte();
    for (int k = 0; k < 8; k++) fall_w();
    sda_d = 1'b0;
    fall_w();
    sda_d = 1'b1;
  endtask : ack_byte
  task automatic stop();
    #80;
    sda_d = 1'b0;
    #80;
    clk_hi();
    sda_d = 1'b1;
    #80;
  endtask : stop
endmodule : far_master

// ---- pin_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the settled value.
module pin_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin in and synchronised view
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~last_r;
  assign fall  = ~sync_r & last_r;
endmodule : pin_sync

// ---- two_wire_master_rx_slave_rx_bench.sv ----
// Self-checking bench for the two-wire unit and its register bus.
`timescale 1ns/1ps
module two_wire_master_rx_slave_rx_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic        scl_oe_n, sda_oe_n, scl_d, sda_d, stuck, wake_req, ack;
  wire         scl_i = scl_d & scl_oe_n;
  wire         sda_i = sda_d & sda_oe_n;
  int          error_cnt, n_compared;

  two_wire_unit #(.HALF_CYCLES(8)) u_two_wire_unit (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl_i),
    .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_oe_n(sda_oe_n), .wake_req(wake_req));
  far_master u_far_master (.scl_w(scl_i), .sda_w(sda_i), .scl_d(scl_d), .sda_d(sda_d),
                           .stuck(stuck));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic hung();
    chk("handshake", 32'h1, 32'h0);
    end_sim();
  endtask : hung
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      // Look on the falling edge, where what the next rising edge will take has settled.
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (b_ok) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) hung();
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int n;
    logic ar_ok, r_ok;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (r_ok) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) hung();
  endtask : rd
  task automatic ctl(input logic [7:0] d);
    wr(two_wire_pkg::ADDR_CONTROL, d);
  endtask : ctl
  task automatic flag_st(input logic [7:0] e);
    int n;
    for (n = 0; n < 600; n++) begin
      rd(two_wire_pkg::ADDR_CONTROL);
      if (rd_v[two_wire_pkg::BIT_FLAG] === 1'b1) break;
    end
    if (n == 600) hung();
    rd(two_wire_pkg::ADDR_STATUS);
    chk("status", {24'h0, e}, rd_v & 32'hF8);
  endtask : flag_st

  // Reset values and an unmapped read.
  task automatic t_regs();
    rd(two_wire_pkg::ADDR_CONTROL);
    chk("control", 32'h0, rd_v);
    rd(two_wire_pkg::ADDR_STATUS);
    chk("status", 32'hF8, rd_v);
    rd(4'h2);
    chk("resp", 32'h2, {30'h0, rd_r});
  endtask : t_regs
  // Own address write, a data byte, then a refused byte after ack enable drops.
  task automatic t_slave();
    wr(two_wire_pkg::ADDR_OWN, 8'h52);
    ctl(8'h44);
    u_far_master.start();
    u_far_master.put_byte(8'h52, ack);
    chk("addr ack", 32'h1, {31'h0, ack});
    flag_st(8'h60);
    chk("stretch", 32'h0, {31'h0, scl_oe_n});
    ctl(8'hC4);
    u_far_master.put_byte(8'hA5, ack);
    chk("data ack", 32'h1, {31'h0, ack});
    flag_st(8'h80);
    rd(two_wire_pkg::ADDR_DATA);
    chk("data", 32'hA5, rd_v);
    ctl(8'h84);
    u_far_master.put_byte(8'h3C, ack);
    chk("data nack", 32'h0, {31'h0, ack});
    flag_st(8'h88);
    ctl(8'hC4);
    u_far_master.stop();
  endtask : t_slave
  // Isolation, general call off and on, and a match while asleep.
  task automatic t_gcall();
    ctl(8'h04);
    u_far_master.start();
    u_far_master.put_byte(8'h52, ack);
    chk("isolated", 32'h0, {31'h0, ack});
    u_far_master.stop();
    ctl(8'h44);
    u_far_master.start();
    u_far_master.put_byte(8'h00, ack);
    chk("gc off", 32'h0, {31'h0, ack});
    u_far_master.stop();
    wr(two_wire_pkg::ADDR_OWN, 8'h53);
    ctl(8'h46);
    u_far_master.start();
    u_far_master.put_byte(8'h00, ack);
    chk("gc ack", 32'h1, {31'h0, ack});
    flag_st(8'h70);
    chk("wake", 32'h1, {31'h0, wake_req});
    chk("sleep hold", 32'h0, {31'h0, scl_oe_n});
    ctl(8'hC4);
    u_far_master.stop();
    ctl(8'h84);
  endtask : t_gcall
  // A START as master, the read address, two received bytes, then a STOP.
  task automatic t_master();
    ctl(8'hA4);
    flag_st(8'h08);
    wr(two_wire_pkg::ADDR_DATA, 8'h53);
    ctl(8'h84);
    u_far_master.ack_byte();
    flag_st(8'h40);
    ctl(8'hC4);
    flag_st(8'h50);
    rd(two_wire_pkg::ADDR_DATA);
    chk("rx data", 32'hFF, rd_v);
    ctl(8'h84);
    flag_st(8'h58);
    ctl(8'h94);
    repeat (64) @(posedge aclk);
    rd(two_wire_pkg::ADDR_CONTROL);
    chk("stop cleared", 32'h0, rd_v & 32'h10);
    rd(two_wire_pkg::ADDR_STATUS);
    chk("idle status", {24'h0, two_wire_pkg::ST_IDLE}, rd_v);
  endtask : t_master

  initial begin
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_slave();
    t_gcall();
    t_master();
    chk("stretch bound", 32'h0, {31'h0, stuck});
    end_sim();
  end
endmodule : two_wire_master_rx_slave_rx_bench

// ---- two_wire_pkg.sv ----
// Package with register map, field positions, status codes and timing constants.
package two_wire_pkg;
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_DATA    = 4'h8;
  localparam logic [3:0] ADDR_OWN     = 4'hC;
  localparam int BIT_FLAG   = 7;
  localparam int BIT_ACK    = 6;
  localparam int BIT_START  = 5;
  localparam int BIT_STOP   = 4;
  localparam int BIT_WCOL   = 3;
  localparam int BIT_EN     = 2;
  localparam int BIT_SLEEP  = 1;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] OWN_RST     = 8'h00;
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_RSTART   = 8'h10;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_RA_ACK   = 8'h40;
  localparam logic [7:0] ST_RA_NACK  = 8'h48;
  localparam logic [7:0] ST_RD_ACK   = 8'h50;
  localparam logic [7:0] ST_RD_NACK  = 8'h58;
  localparam logic [7:0] ST_SW_ACK   = 8'h60;
  localparam logic [7:0] ST_SW_ARB   = 8'h68;
  localparam logic [7:0] ST_GC_ACK   = 8'h70;
  localparam logic [7:0] ST_GC_ARB   = 8'h78;
  localparam logic [7:0] ST_SD_ACK   = 8'h80;
  localparam logic [7:0] ST_SD_NACK  = 8'h88;
  localparam logic [7:0] ST_GD_ACK   = 8'h90;
  localparam logic [7:0] ST_GD_NACK  = 8'h98;
  localparam logic [7:0] ST_STOP_SL  = 8'hA0;
  localparam logic [7:0] ST_SLAVE_TX = 8'hA8;
  localparam logic [7:0] ST_IDLE     = 8'hF8;
  localparam logic [7:0] GC_ADDR     = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CLK_MHZ = 125;
  localparam int BIT_HALF_NS = 5000;
  localparam int HALF_CYC = (BIT_HALF_NS * CLK_MHZ) / 1000;
endpackage : two_wire_pkg

// ---- two_wire_unit.sv ----
`timescale 1ns/1ps
// Two-wire master receiver and slave receiver with AXI4-Lite register access.

// Notes on behaviour
// R1: After START status 08; address-plus-read loaded with flag write sends it, samples acknowledge.
// R2: After repeated START status 10; write-form address switches to master transmitter; code quits master mode to idle with status 60, no flag.
// R3: Arbitration lost gives 38; start request zero releases, one restarts when bus free.
// R4: Read address acknowledged gives 40; next byte answered per ack enable.
// R5: Read address not acknowledged gives 48; start/stop requests pick restart, stop, both.
// R6: Byte received and acknowledged gives 50; ack enable chooses next answer.
// R7: Byte received with NACK gives 58; requests select restart, stop or both.
// R8: Own address upper seven bits; low bit enables general call address zero.
// R9: Software prepares slave reception with enable and ack set, others zero.
// R10: When addressed, direction zero selects slave receiver, else slave transmitter; code sets A8 and goes idle on any read-form address if ack enabled.
// R11: Own address with write bit sets flag with a valid status code.
// R12: Ack enable cleared mid-transfer gives NACK after next received byte.
// R13: Ack enable zero ignores own address but bus is still monitored.
// R14: Asleep with ack enable set, address match still happens and wakes.
// R15: After match while asleep, clock held low until flag written one.
// R16: Data register need not hold last bus byte after deep sleep wake.
// R17: Addressed after lost arbitration gives 68 own or 78 general call; code never sets 68 or 78, master_r being always clear in the slave states.
// R18: Software treats prescaler status bits as zero.
// R19: Received byte valid in data register when flag sets; read while high.
// R20: While flag set, clock stretched low, no bus action until flag written.
module two_wire_unit #(
  parameter int HALF_CYCLES = two_wire_pkg::HALF_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Bus pins, enable low means drive low
  input  wire logic        scl_i,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_oe_n,
  // Wake request toward the power controller
  output logic             wake_req
);
  if (HALF_CYCLES < 4 || HALF_CYCLES > 65535) begin : g_bad_half
    $error("HALF_CYCLES out of range");
  end

  typedef enum logic [7:0] {
    S_IDLE  = 8'b00000001,
    S_START = 8'b00000010,
    S_SHIFT = 8'b00000100,
    S_ACK   = 8'b00001000,
    S_HOLD  = 8'b00010000,
    S_STOP  = 8'b00100000,
    S_SLAVE = 8'b01000000,
    S_SACK  = 8'b10000000
  } state_e;

  state_e      state_r;
  logic [7:0]  control_r, own_r, status_r, data_r, shift_r;
  logic [2:0]  bit_r;
  logic [15:0] tick_r;
  logic [1:0]  phase_r;
  logic        master_r, tx_r, addr_phase_r, gc_r, arb_r, busy_r, restart_pend_r;
  logic        scl_low_r, sda_low_r, ack_slot_r;
  logic        scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;
  logic        aw_hold_r, w_hold_r;
  logic [3:0]  aw_addr_r;
  logic [7:0]  w_data_r;
  logic        wr_go, flag_clear, set_flag;
  logic [7:0]  set_status;
  logic        tick;

  pin_sync u_scl (.aclk(aclk), .aresetn(aresetn), .pin(scl_i),
                  .level(scl_s), .rise(scl_rise), .fall(scl_fall));
  pin_sync u_sda (.aclk(aclk), .aresetn(aresetn), .pin(sda_i),
                  .level(sda_s), .rise(sda_rise), .fall(sda_fall));

  wire start_cond = sda_fall & scl_s;
  wire stop_cond  = sda_rise & scl_s;
  wire flag       = control_r[two_wire_pkg::BIT_FLAG];
  wire ack_en     = control_r[two_wire_pkg::BIT_ACK];
  wire en         = control_r[two_wire_pkg::BIT_EN];

  // AXI4-Lite write: address and data are taken independently in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r  <= 8'h00;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= s_axi_wstrb[0];
        w_data_r <= s_axi_wdata[7:0];
      end
      if (s_axi_wvalid && s_axi_wready && !s_axi_wstrb[0]) w_hold_r <= 1'b1;
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic wstrb0_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) wstrb0_r <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready) wstrb0_r <= s_axi_wstrb[0];
  end
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign s_axi_bresp   = two_wire_pkg::RESP_OKAY;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_en = wr_go && wstrb0_r;
  assign flag_clear = wr_en && aw_addr_r == two_wire_pkg::ADDR_CONTROL
                      && w_data_r[two_wire_pkg::BIT_FLAG];

  // AXI4-Lite read with a registered answer one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= two_wire_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= two_wire_pkg::RESP_OKAY;
      case (s_axi_araddr)
        two_wire_pkg::ADDR_CONTROL: s_axi_rdata <= {24'h000000, control_r};
        two_wire_pkg::ADDR_STATUS:  s_axi_rdata <= {24'h000000, status_r}; // [R18]
        two_wire_pkg::ADDR_DATA:    s_axi_rdata <= {24'h000000, data_r}; // [R19]
        two_wire_pkg::ADDR_OWN:     s_axi_rdata <= {24'h000000, own_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= two_wire_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Control: hardware set of the flag wins over a software clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_r <= two_wire_pkg::CONTROL_RST;
      own_r     <= two_wire_pkg::OWN_RST;
    end else begin
      if (wr_en && aw_addr_r == two_wire_pkg::ADDR_OWN) own_r <= w_data_r; // [R8]
      if (wr_en && aw_addr_r == two_wire_pkg::ADDR_CONTROL) begin
        control_r <= {1'b0, w_data_r[6:4], control_r[3], w_data_r[2:0]}; // [R9]
        control_r[two_wire_pkg::BIT_FLAG] <= flag & ~w_data_r[two_wire_pkg::BIT_FLAG];
        control_r[two_wire_pkg::BIT_WCOL] <= flag & ~w_data_r[two_wire_pkg::BIT_FLAG];
      end
      if (wr_en && aw_addr_r == two_wire_pkg::ADDR_DATA && flag && !flag_clear)
        control_r[two_wire_pkg::BIT_WCOL] <= 1'b0;
      if (wr_en && aw_addr_r == two_wire_pkg::ADDR_DATA && !flag)
        control_r[two_wire_pkg::BIT_WCOL] <= 1'b1;
      if (state_r == S_STOP && tick && phase_r == 2'd2)
        control_r[two_wire_pkg::BIT_STOP] <= 1'b0; // [R5] [R7]
      if (set_flag) control_r[two_wire_pkg::BIT_FLAG] <= 1'b1; // [R11]
    end
  end

  // Quarter-bit tick; held at zero in the idle and slave states, still running while the flag stretches the clock.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r == S_IDLE || state_r == S_SLAVE || state_r == S_SACK)
      tick_r <= 16'h0000;
    else if (tick) tick_r <= 16'h0000;
    else tick_r <= tick_r + 16'h0001;
  end
  assign tick = tick_r == 16'(HALF_CYCLES - 1);

  // Bus sequencer for master receive and slave receive.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      status_r <= two_wire_pkg::ST_IDLE;
      data_r <= 8'h00;
      shift_r <= 8'h00;
      bit_r <= 3'd7;
      phase_r <= 2'd0;
      master_r <= 1'b0;
      tx_r <= 1'b0;
      addr_phase_r <= 1'b0;
      gc_r <= 1'b0;
      arb_r <= 1'b0;
      busy_r <= 1'b0;
      restart_pend_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      set_flag <= 1'b0;
      ack_slot_r <= 1'b0;
    end else begin
      set_flag <= 1'b0;
      if (wr_en && aw_addr_r == two_wire_pkg::ADDR_DATA && flag) data_r <= w_data_r; // [R1]
      if (start_cond) busy_r <= 1'b1;
      if (stop_cond) busy_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          scl_low_r <= 1'b0;
          sda_low_r <= 1'b0;
          if (en && !flag && control_r[two_wire_pkg::BIT_START] && !busy_r) begin
            state_r <= S_START; // [R3]
            phase_r <= 2'd0;
          end else if (en && start_cond) begin
            state_r <= S_SLAVE; // [R13]
            addr_phase_r <= 1'b1;
            bit_r <= 3'd7;
          end
        end
        S_START: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) begin sda_low_r <= 1'b0; scl_low_r <= 1'b0; end
          if (phase_r == 2'd1) sda_low_r <= 1'b1;
          if (phase_r == 2'd2) begin
            scl_low_r <= 1'b1;
            master_r <= 1'b1;
            status_r <= restart_pend_r ? two_wire_pkg::ST_RSTART
                                       : two_wire_pkg::ST_START; // [R1] [R2]
            restart_pend_r <= 1'b1;
            set_flag <= 1'b1;
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          scl_low_r <= 1'b1; // [R15] [R20]
          if (flag_clear) begin
            phase_r <= 2'd0;
            bit_r <= 3'd7;
            if (!master_r) begin
              scl_low_r <= 1'b0;
              state_r <= S_SLAVE; // [R15]
            end else if (status_r == two_wire_pkg::ST_START
                         || status_r == two_wire_pkg::ST_RSTART) begin
              tx_r <= 1'b1;
              shift_r <= data_r; // [R1]
              addr_phase_r <= 1'b1;
              state_r <= S_SHIFT;
            end else if (status_r == two_wire_pkg::ST_ARB_LOST) begin
              master_r <= 1'b0; // [R3]
              scl_low_r <= 1'b0;
              restart_pend_r <= 1'b0;
              state_r <= S_IDLE;
            end else if (w_data_r[two_wire_pkg::BIT_STOP]) begin
              state_r <= S_STOP; // [R5] [R7]
            end else if (w_data_r[two_wire_pkg::BIT_START]) begin
              state_r <= S_START; // [R5] [R7]
            end else begin
              tx_r <= 1'b0;
              addr_phase_r <= 1'b0;
              state_r <= S_SHIFT; // [R4] [R6]
            end
          end
        end
        S_SHIFT: if (tick) begin
          phase_r <= phase_r + 2'd1;
          case (phase_r)
            2'd0: sda_low_r <= tx_r & ~shift_r[7];
            2'd1: scl_low_r <= 1'b0;
            2'd2: begin
              if (tx_r && shift_r[7] && !sda_s) begin
                arb_r <= 1'b1; // [R3]
                sda_low_r <= 1'b0;
              end
              shift_r <= {shift_r[6:0], sda_s};
            end
            default: begin
              scl_low_r <= 1'b1;
              if (arb_r) begin
                arb_r <= 1'b0;
                status_r <= two_wire_pkg::ST_ARB_LOST;
                set_flag <= 1'b1;
                state_r <= S_HOLD;
              end else if (bit_r == 3'd0) begin
                sda_low_r <= ~tx_r & ack_en; // [R4] [R6] [R12]
                state_r <= S_ACK;
              end else bit_r <= bit_r - 3'd1;
            end
          endcase
        end
        S_ACK: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd1) scl_low_r <= 1'b0;
          if (phase_r == 2'd2 && tx_r) begin
            if (addr_phase_r && !data_r[0]) status_r <= two_wire_pkg::ST_RA_NACK;
            else status_r <= sda_s ? two_wire_pkg::ST_RA_NACK
                                   : two_wire_pkg::ST_RA_ACK; // [R4] [R5]
          end
          if (phase_r == 2'd2 && !tx_r) begin
            data_r <= shift_r; // [R19]
            status_r <= sda_low_r ? two_wire_pkg::ST_RD_ACK
                                  : two_wire_pkg::ST_RD_NACK; // [R6] [R7]
          end
          if (phase_r == 2'd3) begin
            scl_low_r <= 1'b1;
            sda_low_r <= 1'b0;
            if (tx_r && !data_r[0]) begin
              master_r <= 1'b0; // [R2]
              status_r <= two_wire_pkg::ST_SW_ACK;
              state_r <= S_IDLE;
            end else begin
              set_flag <= 1'b1;
              state_r <= S_HOLD;
            end
          end
        end
        S_STOP: if (tick) begin
          phase_r <= phase_r + 2'd1;
          if (phase_r == 2'd0) sda_low_r <= 1'b1;
          if (phase_r == 2'd1) scl_low_r <= 1'b0;
          if (phase_r == 2'd2) begin
            sda_low_r <= 1'b0;
            master_r <= 1'b0;
            restart_pend_r <= 1'b0;
            status_r <= two_wire_pkg::ST_IDLE;
            state_r <= S_IDLE; // [R5] then starts again if requested
          end
        end
        S_SLAVE: begin
          ack_slot_r <= 1'b0;
          if (stop_cond) begin
            state_r <= S_IDLE;
          end else if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            if (bit_r == 3'd0) state_r <= S_SACK;
            else bit_r <= bit_r - 3'd1;
          end
        end
        default: begin // S_SACK: acknowledge low phase
          // The slot flag tells the last bit clock from the acknowledge clock, even after a NACK.
          if (scl_fall && !ack_slot_r) begin
            ack_slot_r <= 1'b1;
            gc_r <= addr_phase_r ? shift_r[7:1] == 7'h00 : gc_r;
            if (addr_phase_r && ack_en && shift_r[0]) begin
              status_r <= two_wire_pkg::ST_SLAVE_TX; // [R10]
              state_r <= S_IDLE;
            end else if (addr_phase_r && ack_en && (shift_r[7:1] == own_r[7:1]
                || (shift_r == two_wire_pkg::GC_ADDR && own_r[0]))) begin // [R8] [R13]
              sda_low_r <= 1'b1;
              status_r <= (shift_r == two_wire_pkg::GC_ADDR)
                ? (master_r ? two_wire_pkg::ST_GC_ARB : two_wire_pkg::ST_GC_ACK)
                : (master_r ? two_wire_pkg::ST_SW_ARB : two_wire_pkg::ST_SW_ACK); // [R17]
            end else if (!addr_phase_r) begin
              sda_low_r <= ack_en; // [R12]
              if (control_r[two_wire_pkg::BIT_SLEEP] == 1'b0) data_r <= shift_r; // [R16]
              status_r <= gc_r ? (ack_en ? two_wire_pkg::ST_GD_ACK : two_wire_pkg::ST_GD_NACK)
                               : (ack_en ? two_wire_pkg::ST_SD_ACK : two_wire_pkg::ST_SD_NACK);
            end else begin
              state_r <= S_IDLE; // [R13]
            end
          end else if (scl_fall) begin
            sda_low_r <= 1'b0;
            scl_low_r <= 1'b1; // [R11] [R14] [R15]
            master_r <= 1'b0;
            addr_phase_r <= 1'b0;
            bit_r <= 3'd7;
            set_flag <= 1'b1;
            state_r <= S_HOLD;
          end
        end
      endcase
    end
  end

  // Registered pin drives and wake request.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      wake_req <= 1'b0;
    end else begin
      scl_oe_n <= ~scl_low_r;
      sda_oe_n <= ~sda_low_r;
      wake_req <= control_r[two_wire_pkg::BIT_SLEEP] & flag; // [R14]
    end
  end

  chk_flag_stretch: assert property (@(posedge aclk) disable iff (!aresetn) // [R20]
    (state_r == S_HOLD) [*3] |-> !scl_oe_n) else $error("clock not stretched in hold");
  chk_start_status: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    set_flag && $past(state_r) == S_START && !$past(restart_pend_r)
      |-> status_r == two_wire_pkg::ST_START) else $error("bad start status");
  chk_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
    set_flag |=> flag) else $error("flag not set");
  chk_stop_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    state_r == S_STOP && $changed(state_r) |-> ##[1:600] !control_r[two_wire_pkg::BIT_STOP])
    else $error("stop request not cleared");
  chk_nack_no_ack: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    state_r == S_SHIFT && phase_r == 2'd3 && tick && bit_r == 3'd0 && !tx_r && !ack_en
      |=> !sda_low_r) else $error("ack driven with enable off");
  chk_arb_status: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    arb_r && state_r == S_SHIFT && phase_r == 2'd3 && tick
      |=> status_r == two_wire_pkg::ST_ARB_LOST) else $error("bad arbitration status");
  chk_rd_status: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    state_r == S_ACK && phase_r == 2'd2 && tick && !tx_r && sda_low_r
      |=> status_r == two_wire_pkg::ST_RD_ACK) else $error("bad read status");
  chk_wake_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    wake_req |-> $past(flag)) else $error("wake without flag");
  cov_start: cover property (@(posedge aclk) status_r == two_wire_pkg::ST_START);
  cov_read: cover property (@(posedge aclk) status_r == two_wire_pkg::ST_RD_NACK);
  cov_slave: cover property (@(posedge aclk) status_r == two_wire_pkg::ST_SW_ACK);
endmodule : two_wire_unit
